/* core/gppm_consts.vh */
// Constants for the general purpose page and pin function multiplexer.
`ifndef GPPM_CONSTS_VH
`define GPPM_CONSTS_VH

// Management register addresses (5-bit register number).
`define GPPM_ADDR_PAGE        5'h1f
`define GPPM_ADDR_PINSEL_A    5'h0d
`define GPPM_ADDR_PINSEL_B    5'h0e
`define GPPM_ADDR_GPIO_IN     5'h0f
`define GPPM_ADDR_GPIO_OUT    5'h10
`define GPPM_ADDR_GPIO_OE     5'h11

// Page select values written to the page register.
`define GPPM_PAGE_MAIN        16'h0000
`define GPPM_PAGE_GP          16'h0010

// Pin function field code that hands a pin to GPIO control.
`define GPPM_SEL_GPIO         2'h3

// Field positions in pin_function_select_a.
`define GPPM_A_FIBER_SIGNAL_DETECT_LSB     0
`define GPPM_A_SCL_LSB        8

// Field positions in pin_function_select_b.
`define GPPM_B_SDA_LSB        0
`define GPPM_B_FLF_LSB        2
`define GPPM_B_LOADSAVE_LSB   4
`define GPPM_B_PPS0_LSB       6
`define GPPM_B_PULSE_EN       8
`define GPPM_B_LED_TRI        9
`define GPPM_B_TWS_TRI        10
`define GPPM_B_LP_IN          11
`define GPPM_B_LP_OUT         12
`define GPPM_B_LP_OE_N        13
`define GPPM_B_SPI_LSB        14

// Bits of pin_function_select_b that a write never changes.
`define GPPM_B_RO_MASK        16'h0800

// Reset values.
`define GPPM_RST_PAGE         16'h0000
`define GPPM_RST_PINSEL_A     16'h0000
`define GPPM_RST_PINSEL_B     16'h2600
`define GPPM_RST_GPIO         14'h0000

// Pin counts and register widths.
`define GPPM_GPIO_PINS        14
`define GPPM_LED_PINS         4
`define GPPM_REG_W            16

`endif

/* core/gppm_pin_cell.v */
// One shared pin: input synchroniser and function/GPIO output multiplexer.
`timescale 1ns/100ps
`default_nettype none

module gppm_pin_cell (
	input  wire i_sys_clk,
	input  wire i_reset,
	input  wire i_pin_in,
	input  wire i_sel_gpio,
	input  wire i_func_out,
	input  wire i_func_oe,
	input  wire i_gpio_out,
	input  wire i_gpio_oe,
	output reg  o_pin_out,
	output reg  o_pin_oe,
	output reg  o_pin_level,
	output reg  o_func_in
);

	reg sync1_reg;

	// The pin level only becomes visible after two flops; the first is read by nothing else.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			sync1_reg   <= 1'b0;
			o_pin_level <= 1'b0;
		end else begin
			sync1_reg   <= i_pin_in;
			o_pin_level <= sync1_reg;
		end
	end

	// A pin handed to GPIO feeds its dedicated function a steady zero, so that
	// function logic never sees GPIO traffic as real signalling.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_pin_out <= 1'b0;
			o_pin_oe  <= 1'b0;
			o_func_in <= 1'b0;
		end else if (i_sel_gpio) begin
			o_pin_out <= i_gpio_out;
			o_pin_oe  <= i_gpio_oe;
			o_func_in <= 1'b0;
		end else begin
			o_pin_out <= i_func_out;
			o_pin_oe  <= i_func_oe;
			o_func_in <= o_pin_level;
		end
	end

endmodule

`default_nettype wire

/* core/gppm_pin_mux.v */
// General purpose register page and shared pin function multiplexer.
`timescale 1ns/100ps
`default_nettype none
`include "gppm_consts.vh"

module gppm_pin_mux (
	input  wire        i_sys_clk,
	input  wire        i_reset,
	input  wire        i_soft_reset,
	input  wire [1:0]  i_mgmt_port,
	input  wire [4:0]  i_mgmt_addr,
	input  wire        i_mgmt_wr,
	input  wire        i_mgmt_rd,
	input  wire [15:0] i_mgmt_wdata,
	output reg  [15:0] o_mgmt_rdata,
	output reg         o_gp_page_active,
	input  wire [13:0] i_gpio_pin_in,
	output wire [13:0] o_gpio_pin_out,
	output wire [13:0] o_gpio_pin_oe,
	output wire [3:0]  o_fiber_signal_detect,
	input  wire [3:0]  i_scl_out,
	output wire [3:0]  o_scl_in,
	input  wire        i_sda_out,
	input  wire        i_sda_oe,
	output wire        o_sda_in,
	input  wire        i_fast_link_failure,
	output wire        o_load_save_in,
	input  wire        i_pulse_per_second_0,
	input  wire        i_ts_spi_cs,
	input  wire        i_ts_spi_do,
	input  wire        i_low_power_hold_pin_in,
	output wire        o_low_power_hold_pin_out,
	output wire        o_low_power_hold_pin_oe,
	input  wire [3:0]  i_led_drive,
	input  wire [3:0]  i_led_gpio_mode,
	input  wire [3:0]  i_led_pin_in,
	output wire [3:0]  o_led_pin_out,
	output wire [3:0]  o_led_pin_oe,
	output wire [3:0]  o_led_pin_level,
	input  wire [2:0]  i_pulse_outputs_1_to_3,
	output reg  [2:0]  o_pulse_outputs_1_to_3,
	output reg         o_pulse_outputs_1_to_3_en,
	output reg         o_daisy_chain_input_allowed
);

	reg  [15:0] page_reg;
	reg  [15:0] pinsel_a_reg;
	reg  [15:0] pinsel_b_reg;
	reg  [13:0] gpio_out_reg;
	reg  [13:0] gpio_oe_reg;
	reg  [15:0] rdata_next;

	wire        gp_active;
	wire        gp_wr;
	wire [13:0] gpio_level;
	wire [13:0] sel_gpio;
	wire [13:0] func_out;
	wire [13:0] func_oe;
	wire [13:0] func_in;
	wire        lp_level;
	wire        tws_tri;
	wire        led_tri;
	wire        pulse_en;
	// Write strobes, one for each stored register on the general purpose page.
	wire        wr_pinsel_a;
	wire        wr_pinsel_b;
	wire        wr_gpio_out;
	wire        wr_gpio_oe;

	// The port number is ignored on purpose: every port reaches the same storage.
	assign gp_active = (page_reg == `GPPM_PAGE_GP);
	assign gp_wr     = i_mgmt_wr & gp_active & (i_mgmt_addr != `GPPM_ADDR_PAGE);

	// The page register is main-page state, so a soft reset returns it to the main page.
	always @(posedge i_sys_clk) begin
		if (i_reset || i_soft_reset) begin
			page_reg <= `GPPM_RST_PAGE;
		end else if (i_mgmt_wr && i_mgmt_addr == `GPPM_ADDR_PAGE) begin
			page_reg <= i_mgmt_wdata;
		end
	end

	// The flag trails the page register by one cycle, since every output comes from a flop.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_gp_page_active <= 1'b0;
		end else begin
			o_gp_page_active <= gp_active;
		end
	end

	// Reserved addresses and the input register match none of these strobes,
	// so writes there are simply dropped.
	assign wr_pinsel_a = gp_wr & (i_mgmt_addr == `GPPM_ADDR_PINSEL_A);
	assign wr_pinsel_b = gp_wr & (i_mgmt_addr == `GPPM_ADDR_PINSEL_B);
	assign wr_gpio_out = gp_wr & (i_mgmt_addr == `GPPM_ADDR_GPIO_OUT);
	assign wr_gpio_oe  = gp_wr & (i_mgmt_addr == `GPPM_ADDR_GPIO_OE);

	// Page storage answers only the hardware reset; a soft reset must not disturb
	// pin functions that the board depends on.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			pinsel_a_reg <= `GPPM_RST_PINSEL_A;
		end else if (wr_pinsel_a) begin
			pinsel_a_reg <= i_mgmt_wdata;
		end
	end

	// The pin level bit is never stored, so a stale written value cannot be
	// mistaken for the pin if the read path is ever changed.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			pinsel_b_reg <= `GPPM_RST_PINSEL_B;
		end else if (wr_pinsel_b) begin
			pinsel_b_reg <= i_mgmt_wdata & ~`GPPM_B_RO_MASK;
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			gpio_out_reg <= `GPPM_RST_GPIO;
		end else if (wr_gpio_out) begin
			gpio_out_reg <= i_mgmt_wdata[13:0];
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			gpio_oe_reg <= `GPPM_RST_GPIO;
		end else if (wr_gpio_oe) begin
			gpio_oe_reg <= i_mgmt_wdata[13:0];
		end
	end

	// Read data: reserved and foreign addresses read zero, main page reads zero from here except the page register.
	always @* begin
		rdata_next = 16'h0000;
		if (i_mgmt_addr == `GPPM_ADDR_PAGE) begin
			rdata_next = page_reg;
		end else if (gp_active) begin
			case (i_mgmt_addr)
				`GPPM_ADDR_PINSEL_A: begin
					rdata_next = pinsel_a_reg;
				end
				`GPPM_ADDR_PINSEL_B: begin
					rdata_next = pinsel_b_reg;
					rdata_next[`GPPM_B_LP_IN] = lp_level;
				end
				`GPPM_ADDR_GPIO_IN: begin
					rdata_next = {2'b00, gpio_level};
				end
				`GPPM_ADDR_GPIO_OUT: begin
					rdata_next = {2'b00, gpio_out_reg};
				end
				`GPPM_ADDR_GPIO_OE: begin
					rdata_next = {2'b00, gpio_oe_reg};
				end
				default: begin
					rdata_next = 16'h0000;
				end
			endcase
		end
	end

	// Read data is held between reads, so a slow master may take it late.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_mgmt_rdata <= 16'h0000;
		end else if (i_mgmt_rd) begin
			o_mgmt_rdata <= rdata_next;
		end
	end

	// Only code 11 hands a pin to GPIO; the reserved codes fall back to the
	// dedicated function, which is the less surprising of the undefined outcomes.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sel_a
			assign sel_gpio[gi] =
				(pinsel_a_reg[`GPPM_A_FIBER_SIGNAL_DETECT_LSB+2*gi+1:`GPPM_A_FIBER_SIGNAL_DETECT_LSB+2*gi] ==
				`GPPM_SEL_GPIO);
			assign sel_gpio[gi+4] =
				(pinsel_a_reg[`GPPM_A_SCL_LSB+2*gi+1:`GPPM_A_SCL_LSB+2*gi] ==
				`GPPM_SEL_GPIO);
		end
	endgenerate

	// The remaining pin groups are selected from pin_function_select_b.
	assign sel_gpio[8]  = (pinsel_b_reg[`GPPM_B_SDA_LSB+1:`GPPM_B_SDA_LSB] ==
		`GPPM_SEL_GPIO);
	assign sel_gpio[9]  = (pinsel_b_reg[`GPPM_B_FLF_LSB+1:`GPPM_B_FLF_LSB] ==
		`GPPM_SEL_GPIO);
	assign sel_gpio[10] = (pinsel_b_reg[`GPPM_B_LOADSAVE_LSB+1:`GPPM_B_LOADSAVE_LSB] ==
		`GPPM_SEL_GPIO);
	assign sel_gpio[11] = (pinsel_b_reg[`GPPM_B_PPS0_LSB+1:`GPPM_B_PPS0_LSB] ==
		`GPPM_SEL_GPIO);
	assign sel_gpio[12] = (pinsel_b_reg[`GPPM_B_SPI_LSB+1:`GPPM_B_SPI_LSB] ==
		`GPPM_SEL_GPIO);
	assign sel_gpio[13] = sel_gpio[12];

	assign tws_tri = pinsel_b_reg[`GPPM_B_TWS_TRI];
	assign led_tri = pinsel_b_reg[`GPPM_B_LED_TRI];

	// Signal detect and load/save pins are inputs in their dedicated role.
	assign func_out[3:0] = 4'h0;
	assign func_oe[3:0]  = 4'h0;

	// With the release bit set a high is left to the external pull-up, which lets
	// the bus rise above this device's own supply.
	assign func_out[7:4] = i_scl_out;
	assign func_oe[7:4]  = tws_tri ? ~i_scl_out : 4'hf;
	assign func_out[8]   = i_sda_out;
	assign func_oe[8]    = i_sda_oe & (tws_tri ? ~i_sda_out : 1'b1);

	assign func_out[9]   = i_fast_link_failure;
	assign func_oe[9]    = 1'b1;
	assign func_out[10]  = 1'b0;
	assign func_oe[10]   = 1'b0;
	assign func_out[11]  = i_pulse_per_second_0;
	assign func_oe[11]   = 1'b1;
	assign func_out[12]  = i_ts_spi_cs;
	assign func_oe[12]   = 1'b1;
	assign func_out[13]  = i_ts_spi_do;
	assign func_oe[13]   = 1'b1;

	// Pins 0 to 3 carry fiber signal detect, pins 4 to 7 the serial clocks of PHY0 to PHY3.
	// Pin 8 is serial data, pin 9 fast link failure, pin 10 load/save and pin 11 the
	// pulse-per-second 0 output; pins 12 and 13 are the timestamp SPI pair.
	generate
		for (gi = 0; gi < `GPPM_GPIO_PINS; gi = gi + 1) begin : g_gpio
			gppm_pin_cell u_cell (
				.i_sys_clk   (i_sys_clk),
				.i_reset     (i_reset),
				.i_pin_in    (i_gpio_pin_in[gi]),
				.i_sel_gpio  (sel_gpio[gi]),
				.i_func_out  (func_out[gi]),
				.i_func_oe   (func_oe[gi]),
				.i_gpio_out  (gpio_out_reg[gi]),
				.i_gpio_oe   (gpio_oe_reg[gi]),
				.o_pin_out   (o_gpio_pin_out[gi]),
				.o_pin_oe    (o_gpio_pin_oe[gi]),
				.o_pin_level (gpio_level[gi]),
				.o_func_in   (func_in[gi])
			);
		end
	endgenerate

	assign o_fiber_signal_detect = func_in[3:0];
	assign o_scl_in              = func_in[7:4];
	assign o_sda_in              = func_in[8];
	assign o_load_save_in        = func_in[10];

	// The low-power pin is always under register control, so it uses the GPIO path.
	gppm_pin_cell u_low_power (
		.i_sys_clk   (i_sys_clk),
		.i_reset     (i_reset),
		.i_pin_in    (i_low_power_hold_pin_in),
		.i_sel_gpio  (1'b1),
		.i_func_out  (1'b0),
		.i_func_oe   (1'b0),
		.i_gpio_out  (pinsel_b_reg[`GPPM_B_LP_OUT]),
		.i_gpio_oe   (~pinsel_b_reg[`GPPM_B_LP_OE_N]),
		.o_pin_out   (o_low_power_hold_pin_out),
		.o_pin_oe    (o_low_power_hold_pin_oe),
		.o_pin_level (lp_level),
		.o_func_in   ()
	);

	// LED pins in GPIO mode have no output register of their own, so they act as inputs.
	generate
		for (gi = 0; gi < `GPPM_LED_PINS; gi = gi + 1) begin : g_led
			gppm_pin_cell u_led (
				.i_sys_clk   (i_sys_clk),
				.i_reset     (i_reset),
				.i_pin_in    (i_led_pin_in[gi]),
				.i_sel_gpio  (i_led_gpio_mode[gi]),
				.i_func_out  (i_led_drive[gi]),
				.i_func_oe   (led_tri ? ~i_led_drive[gi] : 1'b1),
				.i_gpio_out  (1'b0),
				.i_gpio_oe   (1'b0),
				.o_pin_out   (o_led_pin_out[gi]),
				.o_pin_oe    (o_led_pin_oe[gi]),
				.o_pin_level (o_led_pin_level[gi]),
				.o_func_in   ()
			);
		end
	endgenerate

	assign pulse_en = pinsel_b_reg[`GPPM_B_PULSE_EN];

	// Pulse outputs 1 to 3 share pins with the daisy-chain input, so the enable
	// also tells the daisy-chain logic whether its input may be used.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_pulse_outputs_1_to_3_en   <= 1'b0;
			o_daisy_chain_input_allowed <= 1'b1;
		end else begin
			o_pulse_outputs_1_to_3_en   <= pulse_en;
			o_daisy_chain_input_allowed <= ~pulse_en;
		end
	end

	// A disabled pulse output rests low, so a daisy-chain partner sharing the
	// pins never sees stray edges from the timestamp logic.
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_pulse_outputs_1_to_3 <= 3'h0;
		end else if (pulse_en) begin
			o_pulse_outputs_1_to_3 <= i_pulse_outputs_1_to_3;
		end else begin
			o_pulse_outputs_1_to_3 <= 3'h0;
		end
	end

endmodule

`default_nettype wire

/* test/gppm_pin_mux_sva.sv */
// Checker for page selection, register reads and low-power pin control.
`timescale 1ns/100ps
`default_nettype none
module gppm_pin_mux_sva (
	input wire logic		i_sys_clk,
	input wire logic		i_reset,
	input wire logic		i_soft_reset,
	input wire logic [4:0]	i_mgmt_addr,
	input wire logic		i_mgmt_wr,
	input wire logic		i_mgmt_rd,
	input wire logic [15:0]	i_mgmt_wdata,
	input wire logic [15:0]	o_mgmt_rdata,
	input wire logic		o_gp_page_active,
	input wire logic		o_low_power_hold_pin_oe,
	input wire logic		o_pulse_outputs_1_to_3_en,
	input wire logic		o_daisy_chain_input_allowed
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_reset);
	// Own page copy, so acceptance is judged at the same edge as the design.
	logic	gp;
	wire logic	w31 = i_mgmt_wr && i_mgmt_addr == 5'h1f;
	always_ff @(posedge i_sys_clk)
		if (i_reset || i_soft_reset)
			gp <= 1'b0;
		else if (w31)
			gp <= i_mgmt_wdata == 16'h0010;
	property p_page_gp;
		w31 && !i_soft_reset && i_mgmt_wdata == 16'h0010 |-> ##2 o_gp_page_active;
	endproperty
	a_page_gp: assert property (p_page_gp) else $error("page not entered");
	property p_page_main;
		w31 && i_mgmt_wdata == 16'h0000 |-> ##2 !o_gp_page_active;
	endproperty
	a_page_main: assert property (p_page_main) else $error("page not left");
	property p_soft;
		i_soft_reset |-> ##2 !o_gp_page_active;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset kept page");
	property p_rd_rsvd;
		i_mgmt_rd && (i_mgmt_addr <= 5'h0c || i_mgmt_addr == 5'h1e) |=> o_mgmt_rdata == 16'h0000;
	endproperty
	a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved read nonzero");
	property p_rd_main;
		i_mgmt_rd && !gp && i_mgmt_addr != 5'h1f |=> o_mgmt_rdata == 16'h0000;
	endproperty
	a_rd_main: assert property (p_rd_main) else $error("main page read nonzero");
	property p_rd_gpio;
		i_mgmt_rd && gp && i_mgmt_addr inside {5'h0f, 5'h10, 5'h11} |=> o_mgmt_rdata[15:14] == 2'h0;
	endproperty
	a_rd_gpio: assert property (p_rd_gpio) else $error("gpio top bits set");
	property p_lp_oe;
		gp && i_mgmt_wr && i_mgmt_addr == 5'h0e
			|-> ##2 o_low_power_hold_pin_oe == !$past(i_mgmt_wdata[13], 2);
	endproperty
	a_lp_oe: assert property (p_lp_oe) else $error("low-power enable wrong");
	property p_lp_rst;
		$fell(i_reset) |-> !o_low_power_hold_pin_oe;
	endproperty
	a_lp_rst: assert property (p_lp_rst) else $error("low-power pin driven");
	property p_pulse;
		o_pulse_outputs_1_to_3_en == !o_daisy_chain_input_allowed;
	endproperty
	a_pulse: assert property (p_pulse) else $error("daisy flag wrong");
	c_gp: cover property (w31 ##2 o_gp_page_active);
	c_lp: cover property (o_low_power_hold_pin_oe);
	c_pulse: cover property (o_pulse_outputs_1_to_3_en);
endmodule
bind gppm_pin_mux gppm_pin_mux_sva chk_u (.*);
`default_nettype wire

/* test/tb_gppm_pin_mux.sv */
// Self-checking bench for the general purpose page and pin mux.
`timescale 1ns/100ps
`default_nettype none
module tb_gppm_pin_mux;
	logic		i_sys_clk, i_reset, i_soft_reset, i_mgmt_wr, i_mgmt_rd, i_sda_out, i_sda_oe;
	logic		i_fast_link_failure, i_pulse_per_second_0, i_ts_spi_cs, i_ts_spi_do;
	logic		i_low_power_hold_pin_in, o_gp_page_active, o_sda_in, o_load_save_in;
	logic		o_low_power_hold_pin_out, o_low_power_hold_pin_oe;
	logic		o_pulse_outputs_1_to_3_en, o_daisy_chain_input_allowed;
	logic [1:0]	i_mgmt_port;
	logic [4:0]	i_mgmt_addr;
	logic [15:0]	i_mgmt_wdata, o_mgmt_rdata;
	logic [13:0]	i_gpio_pin_in, o_gpio_pin_out, o_gpio_pin_oe;
	logic [3:0]	o_fiber_signal_detect, i_scl_out, o_scl_in, i_led_drive, i_led_gpio_mode;
	logic [3:0]	i_led_pin_in, o_led_pin_out, o_led_pin_oe, o_led_pin_level;
	logic [2:0]	i_pulse_outputs_1_to_3, o_pulse_outputs_1_to_3;
	logic [4:0]	rsv [5] = '{5'h00, 5'h05, 5'h0c, 5'h12, 5'h1e};
	int		num_errors = 0;
	int		checked = 0;
	gppm_pin_mux dut_u (.*);
	initial begin
		i_sys_clk = 1'b0;
		forever #12.5 i_sys_clk = ~i_sys_clk;
	end
	task automatic y(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic cp(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [4:0] a, input logic [15:0] d);
		y(1);
		i_mgmt_addr = a;
		i_mgmt_wdata = d;
		i_mgmt_wr = 1'b1;
		y(1);
		i_mgmt_wr = 1'b0;
	endtask
	task automatic cr(input logic [4:0] a, input logic [15:0] e);
		y(1);
		i_mgmt_addr = a;
		i_mgmt_rd = 1'b1;
		y(1);
		i_mgmt_rd = 1'b0;
		y(1);
		cp(o_mgmt_rdata, e);
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		y(3000);
		num_errors++;
		report_and_stop;
	end
	initial begin
		{i_reset, i_soft_reset, i_mgmt_wr, i_mgmt_rd, i_sda_out, i_sda_oe} = 6'h21;
		{i_fast_link_failure, i_pulse_per_second_0, i_ts_spi_cs, i_ts_spi_do} = 4'hf;
		{i_low_power_hold_pin_in, i_mgmt_port, i_mgmt_addr, i_mgmt_wdata} = '0;
		{i_gpio_pin_in, i_scl_out, i_led_drive, i_led_gpio_mode, i_led_pin_in} = '0;
		i_pulse_outputs_1_to_3 = 3'h5;
		y(20);
		i_reset = 1'b0;
		w(5'h1f, 16'h0010);
		cr(5'h0d, 16'h0000);
		cr(5'h0e, 16'h2600);
		cp(16'({o_low_power_hold_pin_oe, o_daisy_chain_input_allowed}), 16'h0001);
		i_mgmt_port = 2'h1;
		w(5'h11, 16'hffff);
		i_mgmt_port = 2'h3;
		cr(5'h11, 16'h3fff);
		w(5'h0d, 16'hffff);
		w(5'h10, 16'h00f0);
		i_gpio_pin_in = 14'h055f;
		y(4);
		cp(16'(o_gpio_pin_out[7:0]), 16'h00f0);
		cp(16'(o_gpio_pin_oe[7:0]), 16'h00ff);
		cp(16'({o_sda_in, o_scl_in, o_fiber_signal_detect}), 16'h0100);
		cr(5'h0f, 16'h055f);
		w(5'h0d, 16'h0000);
		i_scl_out = 4'h5;
		i_led_drive = 4'h5;
		i_sda_out = 1'h1;
		y(4);
		cp(16'({o_sda_in, o_scl_in, o_fiber_signal_detect}), 16'h015f);
		cp(16'(o_gpio_pin_oe[7:4]), 16'h000a);
		cp(16'({o_gpio_pin_oe[8], o_gpio_pin_out[8]}), 16'h0001);
		i_sda_out = 1'h0;
		cp(16'(o_led_pin_oe), 16'h000a);
		w(5'h0e, 16'h2000);
		y(3);
		cp(16'({o_gpio_pin_oe[7:4], o_gpio_pin_out[7:4]}), 16'h00f5);
		cp(16'({o_led_pin_oe, o_led_pin_out}), 16'h00f5);
		i_led_gpio_mode = 4'hf;
		i_led_pin_in = 4'h9;
		y(4);
		cp(16'({o_led_pin_oe, o_led_pin_level}), 16'h0009);
		w(5'h10, 16'h0000);
		w(5'h0e, 16'he2ff);
		y(3);
		cp(16'({o_gpio_pin_oe[13:8], o_gpio_pin_out[13:8]}), 16'h0fc0);
		cp(16'({o_sda_in, o_load_save_in}), 16'h0000);
		w(5'h0e, 16'h2000);
		y(4);
		cp(16'(o_gpio_pin_out[13:11]), 16'h0007);
		cp(16'({o_gpio_pin_out[9], o_gpio_pin_oe[10], o_load_save_in}), 16'h0005);
		cp(16'({o_gpio_pin_oe[8], o_gpio_pin_out[8]}), 16'h0002);
		i_low_power_hold_pin_in = 1'b1;
		w(5'h0e, 16'h1800);
		y(3);
		cp(16'({o_low_power_hold_pin_oe, o_low_power_hold_pin_out}), 16'h0003);
		cr(5'h0e, 16'h1800);
		i_low_power_hold_pin_in = 1'b0;
		y(4);
		cr(5'h0e, 16'h1000);
		w(5'h0e, 16'h0100);
		y(3);
		cp(16'({o_pulse_outputs_1_to_3_en, o_daisy_chain_input_allowed,
			o_pulse_outputs_1_to_3}), 16'h0015);
		w(5'h0e, 16'h0000);
		y(3);
		cp(16'({o_pulse_outputs_1_to_3_en, o_daisy_chain_input_allowed,
			o_pulse_outputs_1_to_3}), 16'h0008);
		w(5'h1f, 16'h0000);
		y(1);
		cp(16'(o_gp_page_active), 16'h0000);
		cr(5'h11, 16'h0000);
		w(5'h1f, 16'h0010);
		y(2);
		cp(16'(o_gp_page_active), 16'h0001);
		i_soft_reset = 1'b1;
		y(1);
		i_soft_reset = 1'b0;
		y(2);
		cp(16'(o_gp_page_active), 16'h0000);
		cr(5'h11, 16'h0000);
		w(5'h11, 16'h0000);
		w(5'h1f, 16'h0010);
		cr(5'h11, 16'h3fff);
		w(5'h05, 16'hffff);
		foreach (rsv[k]) cr(rsv[k], 16'h0000);
		i_reset = 1'b1;
		y(2);
		i_reset = 1'b0;
		w(5'h1f, 16'h0010);
		cr(5'h11, 16'h0000);
		cr(5'h0e, 16'h2600);
		report_and_stop;
	end
endmodule
`default_nettype wire
